/* File: src/acc_top.sv */
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_top
(
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire acc_pkg::acc_pins_t pin_level_i,
  input  wire logic [9:0]      sample_code_i,
  output logic      [15:0]     analog_mask_o,
  output logic      [15:0]     pin_direction_bits_o,
  output logic      [3:0]      input_channel_select_o,
  output logic      [1:0]      reference_source_select_o,
  output logic                 sample_hold_o
);
  import acc_pkg::*;

  // ==========================================================
  // registers
  logic [7:0]  ctrl1_q, ctrl1_d;
  logic [7:0]  ctrl0_q, ctrl0_d;
  logic [15:0] dir_q, dir_d;
  logic [9:0]  res_q, res_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  acc_state_t  st_q, st_d;
  logic [3:0]  tads_q, tads_d;
  logic        abort_seen_q, abort_seen_d;
  logic [15:0] pin_s;
  logic        tick;
  logic        wr, rd;
  logic [3:0]  pcfg;
  logic        go_q;

  acc_sync u_sync
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (pin_level_i),
    .q_o     (pin_s)
  );

  acc_tad_div u_div
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    // restart the bit period on abort so the wait is two whole periods
    .run_i   ((st_q != ACC_IDLE) && !abort_seen_q),
    .tick_o  (tick)
  );

  assign pcfg = ctrl1_q[`ACC_PCFG_MSB:`ACC_PCFG_LSB];
  assign go_q = ctrl0_q[`ACC_GO_BIT];
  assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
  assign rd   = wb_cyc_i && wb_stb_i && !ack_q;

  // ==========================================================
  // analog mask: bit set means channel is analog
  always_comb
  begin
    // top pcfg+1 channels are digital, except 0000 leaves all analog; 1111 covers all sixteen
    if (pcfg == 4'h0)
      analog_mask_o = 16'hffff;
    else
      analog_mask_o = 16'hffff >> (5'(pcfg) + 5'h01);
  end

  // ==========================================================
  // register and conversion next state
  always_comb
  begin
    ctrl1_d      = ctrl1_q;
    ctrl0_d      = ctrl0_q;
    dir_d        = dir_q;
    res_d        = res_q;
    st_d         = st_q;
    tads_d       = tads_q;
    abort_seen_d = 1'b0;
    ack_d        = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d       = 32'h0000_0000;
    if (wr)
    begin
      unique case (wb_adr_i)
        `ACC_CTRL1_ADDR: ctrl1_d = wb_dat_i[7:0] & `ACC_CTRL1_MASK;
        `ACC_CTRL0_ADDR: ctrl0_d = wb_dat_i[7:0] & `ACC_CTRL0_MASK;
        `ACC_RESLO_ADDR: res_d[7:0] = wb_dat_i[7:0];
        `ACC_RESHI_ADDR: res_d[9:8] = wb_dat_i[1:0];
        `ACC_DIR_ADDR:   dir_d = wb_dat_i[15:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (wb_adr_i)
        `ACC_CTRL1_ADDR: rdat_d = {24'h0, ctrl1_q};
        `ACC_CTRL0_ADDR: rdat_d = {24'h0, ctrl0_q};
        `ACC_RESLO_ADDR: rdat_d = {24'h0, res_q[7:0]};
        `ACC_RESHI_ADDR: rdat_d = {30'h0, res_q[9:8]};
        `ACC_PORT_ADDR:  rdat_d = {16'h0, pin_s & ~analog_mask_o};
        `ACC_DIR_ADDR:   rdat_d = {16'h0, dir_q};
        `ACC_STAT_ADDR:  rdat_d = {28'h0, st_q};
        `ACC_ID_ADDR:    rdat_d = {24'h0, `ACC_ID_VALUE}; // arbitrary value
        default:         rdat_d = 32'h0000_0000;
      endcase
    end
    unique case (st_q)
      ACC_IDLE:
        if (go_q && ctrl0_q[`ACC_ON_BIT])
        begin
          st_d   = ACC_ACQ;
          tads_d = 4'h0;
        end
      ACC_ACQ:
        if (tick)
        begin
          tads_d = tads_q + 4'h1;
          if (tads_q == `ACC_ACQ_TADS - 4'h1)
          begin
            st_d   = ACC_CONV;
            tads_d = 4'h0;
          end
        end
      ACC_CONV:
        if (!go_q || !ctrl0_q[`ACC_ON_BIT])
        begin
          st_d         = ACC_WAIT;
          tads_d       = 4'h0;
          abort_seen_d = 1'b1;
        end
        else if (tick)
        begin
          tads_d = tads_q + 4'h1;
          if (tads_q == `ACC_CONV_TADS - 4'h1)
          begin
            // whatever the pin presents is converted
            res_d   = sample_code_i;
            ctrl0_d[`ACC_GO_BIT] = 1'b0;
            st_d    = ACC_IDLE;
          end
        end
      ACC_WAIT:
        if (tick)
        begin
          tads_d = tads_q + 4'h1;
          if (tads_q == `ACC_ABORT_TADS - 4'h1)
          begin
            st_d   = ACC_ACQ;
            tads_d = 4'h0;
          end
        end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl1_q      <= `ACC_CTRL1_RST;
      ctrl0_q      <= 8'h00;
      dir_q        <= 16'hffff;
      res_q        <= 10'h000;
      st_q         <= ACC_IDLE;
      tads_q       <= 4'h0;
      abort_seen_q <= 1'b0;
      ack_q        <= 1'b0;
      rdat_q       <= 32'h0000_0000;
    end
    else
    begin
      ctrl1_q      <= ctrl1_d;
      ctrl0_q      <= ctrl0_d;
      dir_q        <= dir_d;
      res_q        <= res_d;
      st_q         <= st_d;
      tads_q       <= tads_d;
      abort_seen_q <= abort_seen_d;
      ack_q        <= ack_d;
      rdat_q       <= rdat_d;
    end
  end

  assign wb_ack_o                  = ack_q;
  assign wb_dat_o                  = rdat_q;
  assign pin_direction_bits_o      = dir_q;
  assign input_channel_select_o    = ctrl0_q[`ACC_CHS_MSB:`ACC_CHS_LSB];
  assign reference_source_select_o = ctrl1_q[`ACC_VREF_MSB:`ACC_VREF_LSB];
  assign sample_hold_o             = (st_q == ACC_CONV);

  // ==========================================================
  // checks
  upper_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ctrl1_q[7:6] == 2'b00) else $error("control upper bits set");
  abort_now_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_q == ACC_CONV && !go_q) |=> st_q == ACC_WAIT) else $error("abort late");
  abort_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (abort_seen_q && !$past(wr)) |-> res_q == $past(res_q))
    else $error("result changed on abort");
  restart_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    abort_seen_q |-> ##[1:100] st_q == ACC_ACQ) else $error("no auto restart");
  wait_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(st_q == ACC_WAIT) |-> (st_q == ACC_WAIT) [*8]) else $error("wait too short");
  done_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($past(st_q) == ACC_CONV && st_q == ACC_IDLE) |-> !go_q)
    else $error("trigger not cleared");
  mask_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pcfg == 4'hf) |-> analog_mask_o == 16'h0000) else $error("mask wrong");
  port_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (rd && wb_adr_i == `ACC_PORT_ADDR && pcfg == 4'h0) |=> wb_dat_o == 32'h0)
    else $error("analog pin read high");
  ack_drop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  conv_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_q == ACC_CONV ##1 st_q == ACC_IDLE);
  abort_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    abort_seen_q);
  restart_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_q == ACC_WAIT ##1 st_q == ACC_ACQ);
endmodule
`default_nettype wire

/* File: inc/acc_regs.svh */
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ==========================================================
// register byte addresses
`define ACC_CTRL1_ADDR   8'h00
`define ACC_CTRL0_ADDR   8'h04
`define ACC_RESLO_ADDR   8'h08
`define ACC_RESHI_ADDR   8'h0c
`define ACC_PORT_ADDR    8'h10
`define ACC_DIR_ADDR     8'h14
`define ACC_STAT_ADDR    8'h18
`define ACC_ID_ADDR      8'h1c

// ==========================================================
// fields
`define ACC_CTRL1_MASK   8'h3f
`define ACC_CTRL1_RST    8'h00
`define ACC_PCFG_LSB     0
`define ACC_PCFG_MSB     3
`define ACC_VREF_LSB     4
`define ACC_VREF_MSB     5
`define ACC_ON_BIT       0
`define ACC_GO_BIT       1
`define ACC_CHS_LSB      2
`define ACC_CHS_MSB      5
`define ACC_CTRL0_MASK   8'h3f
`define ACC_ID_VALUE     8'h5a

// ==========================================================
// timing: bit period and counts
`define ACC_TAD_NS       100
`define ACC_CLK_NS       5
`define ACC_TAD_CYC      ((`ACC_TAD_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_ACQ_TADS     4'h2
`define ACC_CONV_TADS    4'hb
`define ACC_ABORT_TADS   4'h2

`endif

/* File: inc/acc_pkg.sv */
package acc_pkg;
  typedef enum logic [3:0] {
    ACC_IDLE  = 4'b0001,
    ACC_ACQ   = 4'b0010,
    ACC_CONV  = 4'b0100,
    ACC_WAIT  = 4'b1000
  } acc_state_t;
  typedef logic [15:0] acc_pins_t;
endpackage

/* File: src/acc_tad_div.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
// ==========================================================
// bit period enable divider
module acc_tad_div
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      tick_o
);
  localparam int TC = `ACC_TAD_CYC;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  always_comb
  begin
    if (!run_i || cnt_q == 8'(TC - 1))
      cnt_d = 8'h00;
    else
      cnt_d = cnt_q + 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end

  assign tick_o = run_i && (cnt_q == 8'(TC - 1));
endmodule
`default_nettype wire

/* File: src/acc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-stage pin synchroniser
module acc_sync
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] d_i,
  output logic      [15:0] q_o
);
  logic [15:0] s1_q;
  logic [15:0] s2_q;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule
`default_nettype wire

/* File: bench/acc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_top_tb;
  import acc_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic        wb_ack_o;
  logic        sample_hold_o;
  acc_pins_t   pins = 16'h0;
  logic [9:0]  code = 10'h0;
  logic [15:0] analog_mask_o;
  logic [15:0] pin_direction_bits_o;
  logic [3:0]  chs_o;
  logic [1:0]  ref_o;
  logic [31:0] x = 32'h98c6f467;
  int          err_count = 0;
  int          compares = 0;
  int          n;
  int          k;
  int          res_m;

  always #2.5 mclk_i = ~mclk_i;

  acc_top i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_level_i(pins), .sample_code_i(code), .analog_mask_o(analog_mask_o),
    .pin_direction_bits_o(pin_direction_bits_o), .input_channel_select_o(chs_o),
    .reference_source_select_o(ref_o), .sample_hold_o(sample_hold_o));

  // ==========================================================
  // reference model and helpers
  function automatic logic [15:0] amask(input int p);
    return (p == 0) ? 16'hffff : 16'hffff >> (p + 1);
  endfunction

  function void xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
  endfunction

  task end_of_test(input bit hung);
    if (hung)
      err_count++;
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // ==========================================================
  // wishbone classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    c = 0;
    do
    begin
      @(posedge mclk_i);
      c++;
    end while (wb_ack_o !== 1'b1 && c < 50);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (c >= 50)
      end_of_test(1'b1);
  endtask

  task wait_hold();
    n = 0;
    while (sample_hold_o !== 1'b1 && n < 300)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 300)
      end_of_test(1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wb(1'b0, `ACC_CTRL1_ADDR, 32'h0);
    chk(rd, `ACC_CTRL1_RST);
    chk(analog_mask_o, 16'hffff);
    for (k = 0; k < 16; k++)
    begin
      xs();
      wb(1'b1, `ACC_CTRL1_ADDR, {x[31:6], k[1:0], k[3:0]});
      wb(1'b0, `ACC_CTRL1_ADDR, 32'h0);
      chk(rd, {26'h0, k[1:0], k[3:0]});
      chk(ref_o, k[1:0]);
      chk(analog_mask_o, amask(k));
      pins <= x[31:16];
      repeat (3) @(posedge mclk_i);
      wb(1'b0, `ACC_PORT_ADDR, 32'h0);
      chk(rd, x[31:16] & ~amask(k));
    end
    sel <= 4'he;
    wb(1'b1, `ACC_CTRL1_ADDR, 32'h0);
    sel <= 4'hf;
    wb(1'b0, `ACC_CTRL1_ADDR, 32'h0);
    chk(rd, 32'h3f);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // second pass: all pins analog, then outputs driven and all pins digital, still converted
    for (k = 0; k < 2; k++)
    begin
      xs();
      code <= x[9:0];
      res_m = x[9:0];
      wb(1'b1, `ACC_DIR_ADDR, k ? 32'h0 : 32'hffff);
      chk(pin_direction_bits_o, k ? 16'h0 : 16'hffff);
      wb(1'b1, `ACC_CTRL1_ADDR, k ? 32'h0f : 32'h0);
      wb(1'b1, `ACC_CTRL0_ADDR, {26'h0, x[13:10], 2'b01});
      chk(chs_o, x[13:10]);
      wb(1'b1, `ACC_CTRL0_ADDR, {26'h0, x[13:10], 2'b11});
      n = 0;
      do
      begin
        wb(1'b0, `ACC_CTRL0_ADDR, 32'h0);
        n++;
      end while (rd[1] !== 1'b0 && n < 300);
      chk(rd[1], 1'b0);
      wb(1'b0, `ACC_RESLO_ADDR, 32'h0);
      chk(rd, res_m & 32'hff);
      wb(1'b0, `ACC_RESHI_ADDR, 32'h0);
      chk(rd, res_m >> 8);
    end
    xs();
    code <= x[9:0];
    wb(1'b1, `ACC_CTRL0_ADDR, 32'h03);
    wait_hold();
    wb(1'b1, `ACC_CTRL0_ADDR, 32'h01);
    repeat (2) @(posedge mclk_i);
    chk(sample_hold_o, 1'b0);
    wait_hold();
    // two bit periods of wait plus two of acquisition, 20 cycles each
    chk(n >= 70 && n <= 90, 1'b1);
    wb(1'b1, `ACC_CTRL0_ADDR, 32'h0);
    wb(1'b0, `ACC_RESLO_ADDR, 32'h0);
    chk(rd, res_m & 32'hff);
    wb(1'b0, `ACC_RESHI_ADDR, 32'h0);
    chk(rd, res_m >> 8);
    end_of_test(1'b0);
  end
endmodule
`default_nettype wire
